/* bim_interrupt_manager.sv */
// interrupt enable, routing, management and AC lead-off threshold logic
// assumes serial interface, FIFO and converter run on ref_clk and give pulses/levels
`timescale 1ns/1ps
`default_nettype none

module bim_interrupt_manager import bim_pkg::*; #(
	parameter int LEADOFF_CNT = LEADOFF_CYCLES
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire bim_reg_req_type regReq,
	output logic [23:0] regRdata,
	input wire logic statusReadDone,
	input wire logic dcLeadoffCond,
	input wire logic fifoOverflowCond,
	input wire logic cgMonitorCond,
	input wire logic leadsOnCond,
	input wire logic pllUnlockCond,
	input wire logic [3:0] fifoUnreadCount,
	input wire logic sampleInstant,
	input wire logic adcValid,
	input wire logic signed [ADC_W-1:0] adcData,
	input wire logic [1:0] acLeadoffEnable,
	output logic [23:0] statusFlags,
	output bim_pin_type primaryIrqLine,
	output bim_pin_type secondaryIrqLine
);
	// ----------------------------------------
	// register file
	// ----------------------------------------
	logic [23:0] enPrimary;
	logic [23:0] enSecondary;
	logic [23:0] mngr;
	logic [23:0] thr;

	function automatic logic hit(input bim_reg_req_type r, input logic [6:0] a);
		return r.wr && (r.addr == a);
	endfunction

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			enPrimary <= EN_RESET;
			enSecondary <= EN_RESET;
		end else begin
			if (hit(regReq, ADDR_EN_PRI))
				enPrimary <= regReq.data & EN_MASK;
			if (hit(regReq, ADDR_EN_SEC))
				enSecondary <= regReq.data & EN_MASK;
		end
	end

	// threshold writes only retune the comparators; no FIFO or resync side effect
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			mngr <= MNGR_RESET;
			thr <= THR_RESET;
		end else begin
			if (hit(regReq, ADDR_MNGR))
				mngr <= regReq.data & MNGR_MASK;
			if (hit(regReq, ADDR_THR))
				thr <= regReq.data & THR_MASK;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n)
			regRdata <= 24'h000000;
		else begin
			case (regReq.addr)
				ADDR_EN_PRI: regRdata <= enPrimary;
				ADDR_EN_SEC: regRdata <= enSecondary;
				ADDR_MNGR: regRdata <= mngr;
				ADDR_THR: regRdata <= thr;
				default: regRdata <= 24'h000000;
			endcase
		end
	end

	// ----------------------------------------
	// latched condition flags
	// ----------------------------------------
	logic overCond;
	logic underCond;
	logic overFlag;
	logic underFlag;
	logic dcFlag;
	logic cgFlag;
	logic lonFlag;
	logic pllFlag;

	// set beats the read clear, so an event on the clearing edge survives
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			dcFlag <= 1'b0;
			cgFlag <= 1'b0;
			lonFlag <= 1'b0;
			pllFlag <= 1'b0;
		end else begin
			dcFlag <= dcLeadoffCond | (dcFlag & ~statusReadDone);
			cgFlag <= cgMonitorCond | (cgFlag & ~statusReadDone);
			lonFlag <= leadsOnCond | (lonFlag & ~statusReadDone);
			pllFlag <= pllUnlockCond | (pllFlag & ~statusReadDone);
		end
	end

	// ----------------------------------------
	// AC lead-off range detection
	// ----------------------------------------
	logic [ADC_W:0] adcMag;
	logic [ADC_W:0] hiLimit;
	logic [ADC_W:0] loLimit;
	logic [22:0] overTimer;
	logic [22:0] underTimer;
	localparam logic [22:0] TIMER_END = 23'(LEADOFF_CNT);

	assign adcMag = adcData[ADC_W-1] ? (ADC_W+1)'(-adcData) : (ADC_W+1)'(adcData);
	assign hiLimit = (ADC_W+1)'({thr[HI_LSB+7:HI_LSB], 11'h000}); // 2048 times
	assign loLimit = (ADC_W+1)'({thr[7:0], 5'h00}); // 32 times

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			overCond <= 1'b0;
			underCond <= 1'b0;
		end else if (!acLeadoffEnable[1]) begin
			overCond <= 1'b0;
			underCond <= 1'b0;
		end else if (adcValid) begin
			overCond <= adcMag > hiLimit;
			underCond <= adcMag <= loLimit;
		end
	end

	// timers saturate at the end count; the flag follows while the count stays there
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			overTimer <= 23'h000000;
			underTimer <= 23'h000000;
		end else begin
			if (!overCond)
				overTimer <= 23'h000000;
			else if (overTimer != TIMER_END)
				overTimer <= overTimer + 23'h000001;
			if (!underCond)
				underTimer <= 23'h000000;
			else if (underTimer != TIMER_END)
				underTimer <= underTimer + 23'h000001;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			overFlag <= 1'b0;
			underFlag <= 1'b0;
		end else begin
			overFlag <= (overTimer == TIMER_END) | (overFlag & ~statusReadDone);
			underFlag <= (underTimer == TIMER_END) | (underFlag & ~statusReadDone);
		end
	end

	// ----------------------------------------
	// FIFO level
	// ----------------------------------------
	logic fifoLevelFlag;
	always_ff @(posedge ref_clk) begin
		if (!rst_n)
			fifoLevelFlag <= 1'b0;
		else
			fifoLevelFlag <= fifoUnreadCount >= ({1'b0, mngr[FIT_LSB+2:FIT_LSB]} + 4'h1);
	end

	// ----------------------------------------
	// rate pulse
	// ----------------------------------------
	logic [3:0] instantCnt;
	logic [3:0] divMask;
	logic pulseFire;
	logic [23:0] periodCnt;
	logic [23:0] lastPeriod;
	logic [21:0] holdCnt;
	logic ratePulseFlag;

	always_comb begin
		case (mngr[1:0])
			2'h0: divMask = 4'h0;
			2'h1: divMask = 4'h1;
			2'h2: divMask = 4'h3;
			default: divMask = 4'hF;
		endcase
	end
	assign pulseFire = sampleInstant && ((instantCnt & divMask) == 4'h0);

	always_ff @(posedge ref_clk) begin
		if (!rst_n)
			instantCnt <= 4'h0;
		else if (sampleInstant)
			instantCnt <= instantCnt + 4'h1;
	end

	// the sample period is measured, since the data rate is set elsewhere
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			periodCnt <= 24'h000000;
			lastPeriod <= 24'h000004;
		end else if (sampleInstant) begin
			periodCnt <= 24'h000001;
			lastPeriod <= periodCnt;
		end else if (periodCnt != 24'hFFFFFF)
			periodCnt <= periodCnt + 24'h000001;
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			ratePulseFlag <= 1'b0;
			holdCnt <= 22'h000000;
		end else if (pulseFire) begin
			ratePulseFlag <= 1'b1;
			holdCnt <= (lastPeriod[23:2] == 22'h000000) ? 22'h000001 : lastPeriod[23:2];
		end else if (mngr[CLR_MODE_BIT]) begin
			if (holdCnt > 22'h000001)
				holdCnt <= holdCnt - 22'h000001;
			else
				ratePulseFlag <= 1'b0;
		end else if (statusReadDone)
			ratePulseFlag <= 1'b0;
	end

	// ----------------------------------------
	// status vector and line drivers
	// ----------------------------------------
	always_comb begin
		statusFlags = 24'h000000;
		statusFlags[BIT_DC_LEADOFF] = dcFlag;
		statusFlags[BIT_FIFO_LEVEL] = fifoLevelFlag;
		statusFlags[BIT_FIFO_OVF] = fifoOverflowCond;
		statusFlags[BIT_OVER] = overFlag;
		statusFlags[BIT_UNDER] = underFlag;
		statusFlags[BIT_CGMON] = cgFlag;
		statusFlags[BIT_LEADS_ON] = lonFlag;
		statusFlags[BIT_RATE_PULSE] = ratePulseFlag;
		statusFlags[BIT_PLL] = pllFlag;
	end

	function automatic bim_pin_type drivePin(input logic [23:0] en, input logic [23:0] st);
		bim_pin_type p;
		logic req;
		p = '0;
		req = |(en[23:8] & st[23:8]);
		case (bim_drv_type'(en[1:0]))
			BIM_DRV_PUSH: begin
				p.outLevel = ~req;
				p.oe = 1'b1;
			end
			BIM_DRV_OD: begin
				p.outLevel = 1'b0;
				p.oe = req;
			end
			BIM_DRV_OD_PU: begin
				p.outLevel = 1'b0;
				p.oe = req;
				p.pullupEn = 1'b1;
			end
			default: p = '0;
		endcase
		return p;
	endfunction

	assign primaryIrqLine = drivePin(enPrimary, statusFlags);
	assign secondaryIrqLine = drivePin(enSecondary, statusFlags);

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	logic primaryLow;
	assign primaryLow = primaryIrqLine.oe && !primaryIrqLine.outLevel;

	a_line_follows_enable: assert property (
		(enPrimary[1:0] != 2'h0) |-> (primaryLow == |(enPrimary[23:8] & statusFlags[23:8])))
		else $error("primary line disagrees with enabled flags");
	a_secondary_follows: assert property (
		(enSecondary[1:0] == 2'h2 && (enSecondary[23:8] & statusFlags[23:8]) == 16'h0000)
		|-> !secondaryIrqLine.oe)
		else $error("secondary line driven with nothing enabled");
	a_reset_enables: assert property (
		$rose(rst_n) |-> (enPrimary == EN_RESET && enSecondary == EN_RESET))
		else $error("enable registers not at reset value");
	a_reserved_zero: assert property (
		((enPrimary & ~EN_MASK) == 24'h0) && ((mngr & ~MNGR_MASK) == 24'h0) && ((thr & ~THR_MASK) == 24'h0))
		else $error("reserved bits set");
	a_offstate_float: assert property (
		(enPrimary[1:0] == 2'h0) |-> (!primaryIrqLine.oe && !primaryIrqLine.pullupEn))
		else $error("disabled line still driven");
	a_fifo_level: assert property (
		(fifoUnreadCount == 4'({1'b0, mngr[18:16]}) + 4'h1) && $stable(mngr) |=> fifoLevelFlag)
		else $error("fifo level flag missed threshold");
	a_pulse_selfclear: assert property (
		pulseFire && mngr[CLR_MODE_BIT] && lastPeriod == 24'h000008 ##1
		(!pulseFire && $stable(mngr))[*2] |=> !ratePulseFlag)
		else $error("rate pulse flag did not self-clear");
	a_pulse_readclear: assert property (
		!mngr[CLR_MODE_BIT] && ratePulseFlag && !pulseFire && !statusReadDone |=> ratePulseFlag)
		else $error("rate pulse flag dropped without read");
	a_over_flag: assert property (
		(overTimer == TIMER_END) |=> overFlag)
		else $error("over-range flag not set after timeout");
	a_under_hold: assert property (
		underFlag && !statusReadDone |=> underFlag)
		else $error("under-range flag lost before status read");
	a_sticky_clear: assert property (
		pllFlag && statusReadDone && !pllUnlockCond |=> !pllFlag)
		else $error("pll flag not cleared by status read");

	c_primary_low: cover property (primaryLow ##1 !primaryLow);
	c_pulse_div16: cover property (pulseFire && mngr[1:0] == 2'h3);
	c_over_range: cover property ($rose(overFlag));
	c_under_range: cover property ($rose(underFlag));
endmodule // bim_interrupt_manager

`default_nettype wire

/* bim_pkg.sv */
// constants, field layout and carrier types of the interrupt manager
// assumes one 50 MHz clock shared with the serial register interface
package bim_pkg;
	localparam int CLK_HZ = 50_000_000;
	localparam int LEADOFF_TIME_MS = 128;
	localparam int LEADOFF_CYCLES = LEADOFF_TIME_MS * (CLK_HZ / 1000);
	localparam int ADC_W = 20;
	localparam logic [6:0] ADDR_EN_PRI = 7'h02;
	localparam logic [6:0] ADDR_EN_SEC = 7'h03;
	localparam logic [6:0] ADDR_MNGR = 7'h04;
	localparam logic [6:0] ADDR_THR = 7'h05;
	localparam logic [23:0] EN_MASK = 24'h1F8B03;
	localparam logic [23:0] EN_RESET = 24'h000003;
	localparam logic [23:0] MNGR_MASK = 24'h070007;
	localparam logic [23:0] MNGR_RESET = 24'h030004;
	localparam logic [23:0] THR_MASK = 24'h00FFFF;
	localparam logic [23:0] THR_RESET = 24'h00FFFF;
	localparam int BIT_DC_LEADOFF = 20;
	localparam int BIT_FIFO_LEVEL = 19;
	localparam int BIT_FIFO_OVF = 18;
	localparam int BIT_OVER = 17;
	localparam int BIT_UNDER = 16;
	localparam int BIT_CGMON = 15;
	localparam int BIT_LEADS_ON = 11;
	localparam int BIT_RATE_PULSE = 9;
	localparam int BIT_PLL = 8;
	localparam int FIT_LSB = 16;
	localparam int CLR_MODE_BIT = 2;
	localparam int HI_LSB = 8;
	localparam int HI_SHIFT = 11;
	localparam int LO_SHIFT = 5;
	typedef enum logic [1:0] {
		BIM_DRV_OFF = 2'h0,
		BIM_DRV_PUSH = 2'h1,
		BIM_DRV_OD = 2'h2,
		BIM_DRV_OD_PU = 2'h3
	} bim_drv_type;
	typedef struct packed {
		logic wr;
		logic [6:0] addr;
		logic [23:0] data;
	} bim_reg_req_type;
	typedef struct packed {
		logic outLevel;
		logic oe;
		logic pullupEn;
	} bim_pin_type;
endpackage

/* bim_host_model.sv */
// host side of the interrupt lines: resolves line levels, ends status reads
// assumes the bench raises readReq for two cycles per status read
`timescale 1ns/1ps
`default_nettype none
module bim_host_model import bim_pkg::*; (
	input wire logic ref_clk,
	input wire bim_pin_type primaryIrqLine,
	input wire bim_pin_type secondaryIrqLine,
	input wire logic readReq,
	output logic primaryLevel,
	output logic secondaryLevel,
	output logic statusReadDone
);
	logic lastPri = 1'b1;
	logic lastSec = 1'b1;
	logic readQ = 1'b0;
	// ----------------------------------------
	// wire level
	// ----------------------------------------
	// floating line toggles so a stale level never passes
	function automatic logic lineLevel(bim_pin_type p, logic last);
		return p.oe ? p.outLevel : (p.pullupEn ? 1'b1 : ~last);
	endfunction
	assign primaryLevel = lineLevel(primaryIrqLine, lastPri);
	assign secondaryLevel = lineLevel(secondaryIrqLine, lastSec);
	always @(posedge ref_clk) begin
		lastPri <= primaryLevel;
		lastSec <= secondaryLevel;
		readQ <= readReq;
		statusReadDone <= readReq & ~readQ;
	end
endmodule // bim_host_model
`default_nettype wire

/* test_bioimpedance_interrupt_manager.sv */
// self-checking bench of the interrupt manager
// assumes the host model on the irq lines; inputs change on falling edges
`timescale 1ns/1ps
`default_nettype none
module test_bioimpedance_interrupt_manager import bim_pkg::*;;
	localparam int LCNT = 20;
	logic ref_clk, rst_n, readReq, statusReadDone, sampleInstant, adcValid, primaryLevel, secondaryLevel;
	bim_reg_req_type regReq;
	logic [23:0] regRdata, statusFlags;
	logic [4:0] cond;
	logic [3:0] fifoUnreadCount;
	logic signed [ADC_W-1:0] adcData;
	logic [1:0] acLeadoffEnable;
	bim_pin_type primaryIrqLine, secondaryIrqLine;
	int miscompares = 0;
	int samplesChecked = 0;
	int cycles = 0;
	bim_interrupt_manager #(.LEADOFF_CNT(LCNT)) u_bim_interrupt_manager (.ref_clk(ref_clk), .rst_n(rst_n),
		.regReq(regReq), .regRdata(regRdata), .statusReadDone(statusReadDone), .dcLeadoffCond(cond[0]),
		.fifoOverflowCond(cond[1]), .cgMonitorCond(cond[2]), .leadsOnCond(cond[3]), .pllUnlockCond(cond[4]),
		.fifoUnreadCount(fifoUnreadCount), .sampleInstant(sampleInstant), .adcValid(adcValid), .adcData(adcData),
		.acLeadoffEnable(acLeadoffEnable), .statusFlags(statusFlags), .primaryIrqLine(primaryIrqLine),
		.secondaryIrqLine(secondaryIrqLine));
	bim_host_model u_bim_host_model (.ref_clk(ref_clk), .primaryIrqLine(primaryIrqLine),
		.secondaryIrqLine(secondaryIrqLine), .readReq(readReq), .primaryLevel(primaryLevel),
		.secondaryLevel(secondaryLevel), .statusReadDone(statusReadDone));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic finalReport;
		$display("compared %0d mismatched %0d", samplesChecked, miscompares);
		if (miscompares == 0 && samplesChecked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input string name, input logic [23:0] got, input logic [23:0] exp);
		samplesChecked++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic chkBit(input string name, input logic got, input logic exp);
		samplesChecked++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %b seen %b", name, exp, got);
		end
	endtask
	task automatic wait_n(input int n);
		repeat (n) @(negedge ref_clk);
	endtask
	task automatic wr(input logic [6:0] a, input logic [23:0] d);
		regReq = '{1'b1, a, d};
		@(negedge ref_clk) regReq.wr = 1'b0;
		@(negedge ref_clk);
	endtask
	task automatic rd(input logic [6:0] a, output logic [23:0] d);
		regReq.addr = a;
		wait_n(2);
		d = regRdata;
	endtask
	task automatic hostRead;
		readReq = 1'b1;
		wait_n(2);
		readReq = 1'b0;
		wait_n(1);
	endtask
	task automatic adcSample(input logic signed [ADC_W-1:0] v);
		adcData = v;
		adcValid = 1'b1;
		@(negedge ref_clk) adcValid = 1'b0;
		@(negedge ref_clk);
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic tRegs;
		logic [23:0] d;
		logic [6:0] a [5] = '{7'h02, 7'h03, 7'h04, 7'h05, 7'h06};
		logic [23:0] rv [5] = '{24'h000003, 24'h000003, 24'h030004, 24'h00FFFF, 24'h000000};
		logic [23:0] mk [5] = '{24'h1F8B03, 24'h1F8B03, 24'h070007, 24'h00FFFF, 24'h000000};
		for (int i = 0; i < 5; i++) begin
			rd(a[i], d);
			chk("reset value", d, rv[i]);
		end
		for (int i = 0; i < 5; i++) begin
			wr(a[i], 24'hFFFFFF);
			rd(a[i], d);
			chk("writable bits", d, mk[i]);
		end
	endtask
	task automatic tRoute;
		int pos [5] = '{20, 18, 15, 11, 8};
		wr(7'h02, 24'h1F8B03);
		wr(7'h03, 24'h000003);
		for (int i = 0; i < 5; i++) begin
			cond[i] = 1'b1;
			wait_n(2);
			chkBit("flag set", statusFlags[pos[i]], 1'b1);
			chkBit("primary low", primaryLevel, 1'b0);
			chkBit("secondary idle", secondaryLevel, 1'b1);
			cond[i] = 1'b0;
			wait_n(2);
			chkBit("flag held", statusFlags[pos[i]], i != 1);
			hostRead();
			chkBit("flag cleared", statusFlags[pos[i]], 1'b0);
			chkBit("primary released", primaryLevel, 1'b1);
		end
		wr(7'h02, 24'h000003);
		wr(7'h03, 24'h000103);
		cond[4] = 1'b1;
		wait_n(2);
		chkBit("primary masked", primaryLevel, 1'b1);
		chkBit("secondary low", secondaryLevel, 1'b0);
		cond[4] = 1'b0;
		hostRead();
	endtask
	task automatic tTypes;
		for (int t = 0; t < 4; t++) begin
			for (int r = 0; r < 2; r++) begin
				wr(7'h02, 24'h000100 | 24'(t));
				cond[4] = r[0];
				wait_n(2);
				chk("pin drive", {21'h0, primaryIrqLine.oe, primaryIrqLine.pullupEn,
					primaryIrqLine.oe & primaryIrqLine.outLevel},
					{21'h0, (t == 1) || (t > 1 && r == 1), t == 3, t == 1 && r == 0});
				cond[4] = 1'b0;
				hostRead();
			end
		end
	endtask
	task automatic tFifo;
		for (int th = 0; th < 8; th++) begin
			wr(7'h04, {5'h00, 3'(th), 16'h0004});
			fifoUnreadCount = 4'(th);
			wait_n(2);
			chkBit("fifo below", statusFlags[19], 1'b0);
			fifoUnreadCount = 4'(th + 1);
			wait_n(2);
			chkBit("fifo level", statusFlags[19], 1'b1);
		end
		fifoUnreadCount = 4'h0;
	endtask
	task automatic tPulse;
		int hits;
		int want [4] = '{16, 8, 4, 1};
		// prime the period measure so no checked hold spans a quarter of the idle time since reset
		sampleInstant = 1'b1;
		@(negedge ref_clk) sampleInstant = 1'b0;
		wait_n(7);
		sampleInstant = 1'b1;
		@(negedge ref_clk) sampleInstant = 1'b0;
		for (int f = 0; f < 4; f++) begin
			wr(7'h04, 24'h030004 | 24'(f));
			hits = 0;
			// two leading instants settle the measured period
			for (int n = 0; n < 18; n++) begin
				sampleInstant = 1'b1;
				@(negedge ref_clk) sampleInstant = 1'b0;
				@(negedge ref_clk);
				if (n > 1 && statusFlags[9] === 1'b1)
					hits++;
				wait_n(6);
				chkBit("pulse self clear", statusFlags[9], 1'b0);
			end
			chk("pulse count", 24'(hits), 24'(want[f]));
		end
		wr(7'h04, 24'h030000);
		sampleInstant = 1'b1;
		@(negedge ref_clk) sampleInstant = 1'b0;
		wait_n(8);
		chkBit("pulse held", statusFlags[9], 1'b1);
		hostRead();
		chkBit("pulse read clear", statusFlags[9], 1'b0);
	endtask
	task automatic tRange;
		wr(7'h05, 24'h000101);
		acLeadoffEnable = 2'b10;
		adcSample(20'sd2049);
		wait_n(10);
		chkBit("over early", statusFlags[17], 1'b0);
		wait_n(30);
		chkBit("over set", statusFlags[17], 1'b1);
		adcSample(-20'sd32);
		hostRead();
		chkBit("over cleared", statusFlags[17], 1'b0);
		wait_n(40);
		chkBit("under set", statusFlags[16], 1'b1);
		acLeadoffEnable = 2'b00;
		// condition and timer need two edges to drop; a read before that loses to the set
		wait_n(3);
		hostRead();
		chkBit("under cleared", statusFlags[16], 1'b0);
	endtask
	// ----------------------------------------
	// run
	// ----------------------------------------
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 10000) begin
			miscompares++;
			finalReport();
		end
	end
	initial begin
		rst_n = 1'b0;
		regReq = '0;
		readReq = 1'b0;
		cond = 5'h00;
		fifoUnreadCount = 4'h0;
		sampleInstant = 1'b0;
		adcValid = 1'b0;
		adcData = '0;
		acLeadoffEnable = 2'b00;
		wait_n(4);
		rst_n = 1'b1;
		tRegs();
		tRoute();
		tTypes();
		tFifo();
		tPulse();
		tRange();
		finalReport();
	end
endmodule // test_bioimpedance_interrupt_manager
`default_nettype wire
